// File: src/fam_pkg.sv
// constants, register map and carrier types for the fault action mapper
`default_nettype none
package fam_pkg;
    localparam int CLK_PERIOD_NS  = 8;
    // no reference edge for this long means the reference is dead
    localparam int ACT_TIMEOUT_NS = 8000;
    localparam int ACT_CYC        = ACT_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int ACT_CW         = 11;
    localparam logic [ACT_CW-1:0] ACT_LAST = ACT_CW'(ACT_CYC - 1);

    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_FAULTS  = 8'h08;
    localparam logic [7:0] ADDR_INT_ST  = 8'h0C;
    localparam logic [7:0] ADDR_INT_CLR = 8'h10;
    localparam logic [7:0] ADDR_INT_EN  = 8'h14;
    localparam logic [7:0] ADDR_ACTIONS = 8'h18;

    localparam int CTRL_TX_LSB = 0;
    localparam int CTRL_RX_LSB = 2;
    localparam int CTRL_DI_BIT = 4;
    localparam int CTRL_W      = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
    localparam int NUM_FLT = 15;
    localparam int NUM_EVT = NUM_FLT + 1;

    typedef enum logic [1:0] {
        REF_INTERNAL,
        REF_EXT_TERR,
        REF_EXT_REF,
        REF_LOOP
    } fam_ref_t;

    typedef struct packed {
        logic sat_ais_rx;
        logic sat_ber;
        logic sat_lomf;
        logic sat_lof;
        logic sat_los;
        logic terr_ais_rx;
        logic terr_ber;
        logic terr_lomf;
        logic terr_lof;
        logic terr_sig_loss;
        logic terr_los;
        logic drop_deframer_unlock;
        logic ovs_pll_unlock;
        logic comp_pll_unlock;
        logic if_synth_unlock;
    } fam_faults_t;

    typedef struct packed {
        logic terr_yellow_ts0;
        logic terr_ts16_ones;
        logic terr_ais_ts;
        logic sat_byte32_b3;
        logic sat_ais_ts;
        logic sat_yellow_non_frame_align_word;
        logic service;
        logic prompt;
        logic mod_relay_on;
        logic tx_ais;
        logic tx_minor;
        logic tx_major;
        logic tx_if_off;
    } fam_actions_t;
endpackage
`default_nettype wire

// File: src/fam_fault_action_mapper.sv
// fault to action mapping with reference clock fallback and a wishbone register file
// Function
// RULE1 - rx ref falls back when external reference dies
// RULE2 - rx ref stays internal on activity loss
// RULE3 - tx ref falls back when external reference dies
// RULE4 - tx ref stays internal on activity loss
// RULE5 - synth unlock: if off, major, relay off
// RULE6 - composite pll unlock: if off, major, ais, relay
// RULE7 - oversampling pll unlock: if off, major alarm
// RULE8 - drop deframer unlock in d&i: minor, ais
// RULE9 - terr input loss: prompt, service, yellow, ais
// RULE10 - terr signalling loss: prompt, yellow, ts16 ones
// RULE11 - terr frame loss: prompt, yellow, ais
// RULE12 - terr multiframe loss: prompt, yellow, ts16 ones
// RULE13 - terr ber 1e-3: prompt, yellow, ais
// RULE14 - terr ais received: only byte32 bit3
// RULE15 - sat loss: prompt, service, ais, ts16, byte32
// RULE16 - sat ber 1e-3: same as sat loss
// RULE17 - sat ais received: service, terr ts0 yellow
// RULE18 - actions follow live conditions, released on clear
`default_nettype none
module fam_fault_action_mapper (
    input  wire logic                 clk,          // system clock, 125 MHz
    input  wire logic                 nrst,         // async reset, active low
    input  wire logic                 wb_cyc_i,     // wishbone cycle
    input  wire logic                 wb_stb_i,     // wishbone strobe
    input  wire logic                 wb_we_i,      // wishbone write enable
    input  wire logic [7:0]           wb_adr_i,     // wishbone byte address
    input  wire logic [3:0]           wb_sel_i,     // wishbone byte selects
    input  wire logic [31:0]          wb_dat_i,     // wishbone write data
    output logic      [31:0]          wb_dat_o,     // wishbone read data
    output logic                      wb_ack_o,     // wishbone acknowledge
    input  wire fam_pkg::fam_faults_t fault_in,     // raw fault levels, async
    input  wire logic                 ext_ref_clk,  // external reference clock pin
    input  wire logic                 terr_clk_ok,  // terrestrial clock present
    output fam_pkg::fam_actions_t     act,          // registered fault actions
    output fam_pkg::fam_ref_t         tx_ref,       // effective tx clock reference
    output fam_pkg::fam_ref_t         rx_ref,       // effective buffer clock reference
    output logic                      irq           // level interrupt
);
    fam_pkg::fam_faults_t        flt_s1;
    fam_pkg::fam_faults_t        flt;
    fam_pkg::fam_faults_t        flt_d;
    logic [2:0]                  ref_sync;
    logic [1:0]                  terr_sync;
    logic                        terr_ok;
    logic                        ref_edge;
    logic [fam_pkg::ACT_CW-1:0]  act_cnt;
    logic                        ref_lost;
    logic                        ref_lost_d;
    logic [fam_pkg::CTRL_W-1:0]  ctrl;
    fam_pkg::fam_ref_t           tx_cfg;
    fam_pkg::fam_ref_t           rx_cfg;
    logic                        di_mode;
    logic [fam_pkg::NUM_EVT-1:0] evt;
    logic [fam_pkg::NUM_EVT-1:0] int_stat;
    logic [fam_pkg::NUM_EVT-1:0] int_en;
    logic [fam_pkg::NUM_EVT-1:0] int_clr;
    logic                        wb_req;
    logic                        wb_wr;
    fam_pkg::fam_actions_t       next_act;
    logic [31:0]                 next_rdata;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    // byte-lane merge of write data into an existing word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (wd & m);
    endfunction

    function automatic fam_pkg::fam_ref_t pick_ref(input fam_pkg::fam_ref_t cfg,
                                                   input logic lost, input logic tok);
        if (cfg == fam_pkg::REF_EXT_REF && lost) begin
            pick_ref = tok ? fam_pkg::REF_EXT_TERR : fam_pkg::REF_INTERNAL;
        end else begin
            pick_ref = cfg;
        end
    endfunction

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flt_s1    <= '0;
            flt       <= '0;
            flt_d     <= '0;
            ref_sync  <= 3'h0;
            terr_sync <= 2'h0;
        end else begin
            flt_s1    <= fault_in;
            flt       <= flt_s1;
            flt_d     <= flt;
            ref_sync  <= {ref_sync[1:0], ext_ref_clk};
            terr_sync <= {terr_sync[0], terr_clk_ok};
        end
    end

    assign terr_ok  = terr_sync[1];
    assign ref_edge = ref_sync[2] ^ ref_sync[1];

    // activity monitor: any edge restarts the window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            act_cnt  <= '0;
            ref_lost <= 1'b0;
        end else if (ref_edge) begin
            act_cnt  <= '0;
            ref_lost <= 1'b0;
        end else if (act_cnt == fam_pkg::ACT_LAST) begin
            ref_lost <= 1'b1;
        end else begin
            act_cnt  <= act_cnt + 1'b1;
        end
    end

    assign tx_cfg  = fam_pkg::fam_ref_t'(ctrl[fam_pkg::CTRL_TX_LSB +: 2]);
    assign rx_cfg  = fam_pkg::fam_ref_t'(ctrl[fam_pkg::CTRL_RX_LSB +: 2]);
    assign di_mode = ctrl[fam_pkg::CTRL_DI_BIT];

    // reference fallback, returns to the configured source once activity is back
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_ref <= fam_pkg::REF_INTERNAL;
            rx_ref <= fam_pkg::REF_INTERNAL;
        end else begin
            rx_ref <= pick_ref(rx_cfg, ref_lost, terr_ok); // RULE1 RULE2
            tx_ref <= pick_ref(tx_cfg, ref_lost, terr_ok); // RULE3 RULE4
        end
    end

    // actions are a pure function of live faults and di_mode; each drops when no cause remains, except mod_relay_on, which returns high
    always_comb begin
        next_act                 = '0;
        next_act.tx_if_off       = flt.if_synth_unlock | flt.comp_pll_unlock
                                 | flt.ovs_pll_unlock; // RULE5 RULE6 RULE7
        next_act.tx_major        = flt.if_synth_unlock | flt.comp_pll_unlock
                                 | flt.ovs_pll_unlock; // RULE5 RULE6 RULE7
        next_act.tx_minor        = di_mode & flt.drop_deframer_unlock; // RULE8
        next_act.tx_ais          = flt.comp_pll_unlock
                                 | (di_mode & flt.drop_deframer_unlock); // RULE6 RULE8
        next_act.mod_relay_on    = ~(flt.if_synth_unlock | flt.comp_pll_unlock); // RULE5 RULE6
        next_act.prompt          = flt.terr_los | flt.terr_sig_loss | flt.terr_lof
                                 | flt.terr_lomf | flt.terr_ber | flt.sat_los | flt.sat_lof
                                 | flt.sat_lomf | flt.sat_ber; // RULE9 RULE10 RULE11 RULE12 RULE13
        next_act.service         = flt.terr_los | flt.sat_los | flt.sat_lof | flt.sat_lomf
                                 | flt.sat_ber | flt.sat_ais_rx; // RULE9 RULE15 RULE16 RULE17
        next_act.sat_yellow_non_frame_align_word = flt.terr_los | flt.terr_sig_loss | flt.terr_lof
                                 | flt.terr_lomf | flt.terr_ber; // RULE9 RULE10 RULE11 RULE12
        next_act.sat_ais_ts      = flt.terr_los | flt.terr_lof | flt.terr_ber; // RULE9 RULE13
        next_act.sat_byte32_b3   = flt.terr_ais_rx | flt.sat_los | flt.sat_lof
                                 | flt.sat_lomf | flt.sat_ber; // RULE14 RULE15 RULE16
        next_act.terr_ais_ts     = flt.sat_los | flt.sat_lof | flt.sat_lomf
                                 | flt.sat_ber; // RULE15 RULE16
        next_act.terr_ts16_ones  = flt.terr_sig_loss | flt.terr_lomf | flt.sat_los
                                 | flt.sat_lof | flt.sat_lomf | flt.sat_ber; // RULE10 RULE12
        next_act.terr_yellow_ts0 = flt.sat_ais_rx; // RULE17
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            act <= '0;
        end else begin
            act <= next_act; // RULE18
        end
    end

    // bus slave: one wait state, ack for one cycle
    assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr   = wb_req & wb_we_i;
    assign int_clr = (wb_wr && hit(wb_adr_i, fam_pkg::ADDR_INT_CLR)) ?
                     fam_pkg::NUM_EVT'(merge(32'h0, wb_dat_i, wb_sel_i)) : '0;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= fam_pkg::CTRL_RESET;
        end else if (wb_wr && hit(wb_adr_i, fam_pkg::ADDR_CTRL)) begin
            ctrl <= fam_pkg::CTRL_W'(merge(32'(ctrl), wb_dat_i, wb_sel_i));
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            int_en <= '0;
        end else if (wb_wr && hit(wb_adr_i, fam_pkg::ADDR_INT_EN)) begin
            int_en <= fam_pkg::NUM_EVT'(merge(32'(int_en), wb_dat_i, wb_sel_i));
        end
    end

    assign evt = {ref_lost & ~ref_lost_d, flt & ~flt_d};

    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ref_lost_d <= 1'b0;
            int_stat   <= '0;
            irq        <= 1'b0;
        end else begin
            ref_lost_d <= ref_lost;
            int_stat   <= (int_stat & ~int_clr) | evt;
            irq        <= |(((int_stat & ~int_clr) | evt) & int_en);
        end
    end

    always_comb begin
        next_rdata = 32'h0;
        if (hit(wb_adr_i, fam_pkg::ADDR_CTRL)) begin
            next_rdata = 32'(ctrl);
        end else if (hit(wb_adr_i, fam_pkg::ADDR_STATUS)) begin
            next_rdata = 32'({terr_ok, ref_lost, rx_ref, tx_ref});
        end else if (hit(wb_adr_i, fam_pkg::ADDR_FAULTS)) begin
            next_rdata = 32'(flt);
        end else if (hit(wb_adr_i, fam_pkg::ADDR_INT_ST)) begin
            next_rdata = 32'(int_stat);
        end else if (hit(wb_adr_i, fam_pkg::ADDR_INT_EN)) begin
            next_rdata = 32'(int_en);
        end else if (hit(wb_adr_i, fam_pkg::ADDR_ACTIONS)) begin
            next_rdata = 32'(act);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= (wb_req && !wb_we_i) ? next_rdata : 32'h0;
        end
    end

    a_rx_fallback: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        (rx_cfg == fam_pkg::REF_EXT_REF && ref_lost)
        |=> rx_ref == ($past(terr_ok) ? fam_pkg::REF_EXT_TERR : fam_pkg::REF_INTERNAL))
        else $error("rx reference did not fall back");

    a_rx_stay_int: assert property (@(posedge clk) disable iff (!nrst) // RULE2
        (rx_cfg == fam_pkg::REF_INTERNAL) ##1 (rx_cfg == fam_pkg::REF_INTERNAL)
        |-> rx_ref == fam_pkg::REF_INTERNAL)
        else $error("rx reference left the internal oscillator");

    a_tx_fallback: assert property (@(posedge clk) disable iff (!nrst) // RULE3
        (tx_cfg == fam_pkg::REF_EXT_REF && ref_lost && terr_ok)
        |=> tx_ref == fam_pkg::REF_EXT_TERR)
        else $error("tx reference did not move to terrestrial clock");

    a_tx_stay_int: assert property (@(posedge clk) disable iff (!nrst) // RULE4
        (tx_cfg == fam_pkg::REF_INTERNAL && ref_lost) |=> tx_ref == fam_pkg::REF_INTERNAL)
        else $error("tx reference left the internal oscillator");

    a_ref_timeout: assert property (@(posedge clk) disable iff (!nrst) // RULE1
        ref_edge |=> !ref_lost [*8])
        else $error("reference declared lost too soon after an edge");

    a_synth_act: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        $rose(flt.if_synth_unlock)
        |=> act.tx_if_off && act.tx_major && !act.mod_relay_on)
        else $error("synth unlock actions missing");

    a_comp_act: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        flt.comp_pll_unlock
        |=> act.tx_if_off && act.tx_major && act.tx_ais && !act.mod_relay_on)
        else $error("composite pll unlock actions missing");

    a_ovs_act: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        flt.ovs_pll_unlock |=> act.tx_if_off && act.tx_major)
        else $error("oversampling pll unlock actions missing");

    a_drop_minor: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        1'b1 |=> act.tx_minor == $past(di_mode && flt.drop_deframer_unlock))
        else $error("minor alarm not gated by drop and insert mode");

    a_terr_los: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        flt.terr_los |=> act.prompt && act.service && act.sat_yellow_non_frame_align_word && act.sat_ais_ts)
        else $error("terrestrial input loss actions missing");

    a_terr_sig: assert property (@(posedge clk) disable iff (!nrst) // RULE10
        (flt.terr_sig_loss || flt.terr_lomf)
        |=> act.prompt && act.sat_yellow_non_frame_align_word && act.terr_ts16_ones)
        else $error("terrestrial signalling loss actions missing");

    a_terr_frame: assert property (@(posedge clk) disable iff (!nrst) // RULE11
        (flt.terr_lof || flt.terr_ber)
        |=> act.prompt && act.sat_yellow_non_frame_align_word && act.sat_ais_ts)
        else $error("terrestrial frame or ber actions missing");

    a_terr_ais_only: assert property (@(posedge clk) disable iff (!nrst) // RULE14
        (flt == fam_pkg::fam_faults_t'(15'h0200))
        |=> act.sat_byte32_b3 && !act.prompt && !act.service && !act.sat_yellow_non_frame_align_word)
        else $error("terrestrial ais must only set byte 32 bit 3");

    a_sat_loss: assert property (@(posedge clk) disable iff (!nrst) // RULE15
        (flt.sat_los || flt.sat_lof || flt.sat_lomf || flt.sat_ber)
        |=> act.prompt && act.service && act.terr_ais_ts && act.terr_ts16_ones
            && act.sat_byte32_b3)
        else $error("satellite loss actions missing");

    a_sat_ais_only: assert property (@(posedge clk) disable iff (!nrst) // RULE17
        (flt == fam_pkg::fam_faults_t'(15'h4000))
        |=> act.service && act.terr_yellow_ts0 && !act.prompt && !act.terr_ais_ts)
        else $error("satellite ais must only raise service and ts0 yellow");

    a_release_all: assert property (@(posedge clk) disable iff (!nrst) // RULE18
        (flt == '0) [*2] |=> (act == fam_pkg::fam_actions_t'(13'h0010)))
        else $error("actions held after all faults cleared");

    a_irq_set: assert property (@(posedge clk) disable iff (!nrst)
        (|(evt & int_en)) |=> irq && (int_stat & $past(evt)) == $past(evt))
        else $error("enabled event did not raise interrupt");

    a_ack_once: assert property (@(posedge clk) disable iff (!nrst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_follows: assert property (@(posedge clk) disable iff (!nrst)
        wb_req |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");

    a_dat_idle: assert property (@(posedge clk) disable iff (!nrst)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside acknowledge");

    a_synth_only: assert property (@(posedge clk) disable iff (!nrst) // RULE5
        (flt == fam_pkg::fam_faults_t'(15'h0001))
        |=> act == fam_pkg::fam_actions_t'(13'h0003))
        else $error("synth unlock action set wrong");

    a_comp_only: assert property (@(posedge clk) disable iff (!nrst) // RULE6
        (flt == fam_pkg::fam_faults_t'(15'h0002))
        |=> act == fam_pkg::fam_actions_t'(13'h000B))
        else $error("composite pll unlock action set wrong");

    a_ovs_relay: assert property (@(posedge clk) disable iff (!nrst) // RULE7
        (flt == fam_pkg::fam_faults_t'(15'h0004))
        |=> act == fam_pkg::fam_actions_t'(13'h0013))
        else $error("oversampling pll unlock action set wrong");

    a_drop_gated: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        (!di_mode && flt == fam_pkg::fam_faults_t'(15'h0008))
        |=> act == fam_pkg::fam_actions_t'(13'h0010))
        else $error("drop deframer unlock acted outside drop and insert");

    a_terr_los_only: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        (flt == fam_pkg::fam_faults_t'(15'h0010))
        |=> act == fam_pkg::fam_actions_t'(13'h01F0))
        else $error("terrestrial input loss action set wrong");

    a_ais_only: assert property (@(posedge clk) disable iff (!nrst) // RULE11 RULE13
        (flt == fam_pkg::fam_faults_t'(15'h0040) || flt == fam_pkg::fam_faults_t'(15'h0100))
        |=> act == fam_pkg::fam_actions_t'(13'h01B0))
        else $error("terrestrial frame or ber action set wrong");

    a_ts16_only: assert property (@(posedge clk) disable iff (!nrst) // RULE10 RULE12
        (flt == fam_pkg::fam_faults_t'(15'h0020) || flt == fam_pkg::fam_faults_t'(15'h0080))
        |=> act == fam_pkg::fam_actions_t'(13'h08B0))
        else $error("terrestrial signalling action set wrong");

    a_sat_ber_same: assert property (@(posedge clk) disable iff (!nrst) // RULE15 RULE16
        (flt == fam_pkg::fam_faults_t'(15'h0400) || flt == fam_pkg::fam_faults_t'(15'h2000))
        |=> act == fam_pkg::fam_actions_t'(13'h0E70))
        else $error("satellite loss or ber action set wrong");

    a_loop_pass: assert property (@(posedge clk) disable iff (!nrst)
        (rx_cfg == fam_pkg::REF_LOOP) |=> rx_ref == fam_pkg::REF_LOOP)
        else $error("loop reference not passed through");

    a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
        1'b1 |=> irq == |(int_stat & $past(int_en)))
        else $error("interrupt level disagrees with enabled status");

    a_stat_clear: assert property (@(posedge clk) disable iff (!nrst)
        (|int_clr && !(|evt)) |=> (int_stat & $past(int_clr)) == '0)
        else $error("status bit survived its clear");
endmodule
`default_nettype wire

// File: tb/fam_far_end.sv
// far-end model: external reference clock source and terrestrial clock presence
`default_nettype none
module fam_far_end (
    input  wire logic clk,          // system clock
    input  wire logic nrst,         // async reset, active low
    input  wire logic ref_run,      // reference source alive
    input  wire logic terr_present, // terrestrial clock exists
    output logic      ext_ref_clk,  // external reference clock
    output logic      terr_clk_ok   // terrestrial clock present
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div;
    // a dead source freezes at its last level, it does not go idle low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div <= 2'h0;
            ext_ref_clk <= 1'b0;
        end else if (ref_run) begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                ext_ref_clk <= ~ext_ref_clk;
            end
        end
    end
    assign terr_clk_ok = terr_present;
endmodule
`default_nettype wire

// File: tb/fam_fault_action_mapper_bench.sv
// self-checking bench for the fault action mapper
`default_nettype none
module fam_fault_action_mapper_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
    logic                  ref_run, terr_present, ext_ref_clk, terr_clk_ok;
    logic [7:0]            wb_adr_i;
    logic [3:0]            wb_sel_i;
    logic [31:0]           wb_dat_i, wb_dat_o, q;
    fam_pkg::fam_faults_t  fault_in;
    fam_pkg::fam_actions_t act;
    fam_pkg::fam_ref_t     tx_ref, rx_ref;
    int                    mismatches, n_tests, cyc;
    logic [14:0]           combo [6] = '{15'h0050, 15'h0240, 15'h4400, 15'h4000,
                                         15'h0003, 15'h2104};

    fam_fault_action_mapper i_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fault_in(fault_in),
        .ext_ref_clk(ext_ref_clk), .terr_clk_ok(terr_clk_ok), .act(act), .tx_ref(tx_ref),
        .rx_ref(rx_ref), .irq(irq));
    fam_far_end i_far (.clk(clk), .nrst(nrst), .ref_run(ref_run),
        .terr_present(terr_present), .ext_ref_clk(ext_ref_clk), .terr_clk_ok(terr_clk_ok));

    always #4 clk = ~clk;

    function automatic fam_pkg::fam_actions_t exp_act(input logic [14:0] f, input logic di);
        fam_pkg::fam_actions_t e;
        e = '0;
        e.mod_relay_on = !(f[0] | f[1]);
        e.tx_if_off = f[0] | f[1] | f[2];
        e.tx_major = f[0] | f[1] | f[2];
        e.tx_ais = f[1] | (f[3] & di);
        e.tx_minor = f[3] & di;
        e.prompt = (|f[8:4]) | (|f[13:10]);
        e.service = f[4] | (|f[13:10]) | f[14];
        e.sat_yellow_non_frame_align_word = |f[8:4];
        e.sat_ais_ts = f[4] | f[6] | f[8];
        e.terr_ts16_ones = f[5] | f[7] | (|f[13:10]);
        e.sat_byte32_b3 = f[9] | (|f[13:10]);
        e.terr_ais_ts = |f[13:10];
        e.terr_yellow_ts0 = f[14];
        return e;
    endfunction

    task automatic fail(input string msg);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
    endtask

    task automatic chk_a(input fam_pkg::fam_actions_t got, input fam_pkg::fam_actions_t exp);
        n_tests++;
        if (got !== exp) fail($sformatf("actions %h expected %h", got, exp));
    endtask

    // one classic cycle; held until ack is sampled high, a hang ends at the bench timeout
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk_w(q, exp);
    endtask

    // 2 sync flops plus the action register, with margin
    task automatic put(input logic [14:0] f);
        @(posedge clk);
        fault_in <= fam_pkg::fam_faults_t'(f);
        repeat (5) @(posedge clk);
    endtask

    task automatic conclude();
        if (mismatches == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            fail("timeout");
            conclude();
        end
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        fault_in = '0;
        ref_run = 1'b1;
        terr_present = 1'b1;
        mismatches = 0;
        n_tests = 0;
        cyc = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk_a(act, exp_act(15'h0, 1'b0));
        rd(fam_pkg::ADDR_CTRL, 32'h0);
        rd(fam_pkg::ADDR_INT_EN, 32'h0);
        rd(fam_pkg::ADDR_INT_ST, 32'h0);
        xfer(1'b1, 8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0);
        xfer(1'b1, fam_pkg::ADDR_FAULTS, 32'h7FFF);
        rd(fam_pkg::ADDR_FAULTS, 32'h0);
        for (int m = 0; m < 2; m++) begin
            xfer(1'b1, fam_pkg::ADDR_CTRL, {27'h0, m[0], 4'h0});
            for (int i = 0; i < 15; i++) begin
                put(15'h1 << i);
                chk_a(act, exp_act(15'h1 << i, m[0]));
                rd(fam_pkg::ADDR_FAULTS, {17'h0, 15'h1 << i});
                rd(fam_pkg::ADDR_ACTIONS, {19'h0, exp_act(15'h1 << i, m[0])});
                put(15'h0);
                chk_a(act, exp_act(15'h0, m[0]));
            end
        end
        foreach (combo[k]) begin
            put(combo[k]);
            chk_a(act, exp_act(combo[k], 1'b0));
        end
        put(15'h0);
        // every fault rose once, so event bits 0 to 14 are latched; the reference-loss bit 15 stays clear
        rd(fam_pkg::ADDR_INT_ST, 32'h7FFF);
        xfer(1'b1, fam_pkg::ADDR_INT_CLR, 32'hFFFF);
        rd(fam_pkg::ADDR_INT_ST, 32'h0);
        xfer(1'b1, fam_pkg::ADDR_INT_EN, 32'h2);
        rd(fam_pkg::ADDR_INT_EN, 32'h2);
        put(15'h2);
        chk_w({31'h0, irq}, 32'h1);
        xfer(1'b1, fam_pkg::ADDR_INT_EN, 32'h0);
        repeat (2) @(posedge clk);
        chk_w({31'h0, irq}, 32'h0);
        xfer(1'b1, fam_pkg::ADDR_INT_EN, 32'h2);
        put(15'h0);
        chk_w({31'h0, irq}, 32'h1);
        xfer(1'b1, fam_pkg::ADDR_INT_CLR, 32'h2);
        repeat (2) @(posedge clk);
        chk_w({31'h0, irq}, 32'h0);
        rd(fam_pkg::ADDR_INT_ST, 32'h0);
        // both references on the external reference, then kill it
        xfer(1'b1, fam_pkg::ADDR_CTRL, 32'h0A);
        repeat (10) @(posedge clk);
        chk_w({28'h0, rx_ref, tx_ref}, 32'hA);
        ref_run <= 1'b0;
        repeat (fam_pkg::ACT_CYC + 20) @(posedge clk);
        chk_w({28'h0, rx_ref, tx_ref}, 32'h5);
        rd(fam_pkg::ADDR_STATUS, 32'h35);
        terr_present <= 1'b0;
        repeat (8) @(posedge clk);
        chk_w({28'h0, rx_ref, tx_ref}, 32'h0);
        rd(fam_pkg::ADDR_STATUS, 32'h10);
        ref_run <= 1'b1;
        terr_present <= 1'b1;
        repeat (20) @(posedge clk);
        chk_w({28'h0, rx_ref, tx_ref}, 32'hA);
        rd(fam_pkg::ADDR_STATUS, 32'h2A);
        xfer(1'b1, fam_pkg::ADDR_CTRL, 32'h0);
        ref_run <= 1'b0;
        repeat (fam_pkg::ACT_CYC + 20) @(posedge clk);
        chk_w({28'h0, rx_ref, tx_ref}, 32'h0);
        rd(fam_pkg::ADDR_STATUS, 32'h30);
        // tx on the dead external reference, rx on loop timing: only tx may move
        xfer(1'b1, fam_pkg::ADDR_CTRL, 32'h0E);
        repeat (4) @(posedge clk);
        chk_w({28'h0, rx_ref, tx_ref}, 32'hD);
        rd(fam_pkg::ADDR_INT_ST, 32'h8000);
        conclude();
    end
endmodule
`default_nettype wire
